// ===== hw/clkrst_pkg.sv
// Constants and types shared by the clock and reset manager.
// Assumes one 20 MHz system clock and an active high asynchronous reset.
//
// Contract
// - After any reset, run from the RC oscillator for 1024 cycles first.
// - After start-up, switch to the external source by itself if present.
// - Fall back to the RC oscillator when the external source fails.
// - Keep a readable sticky flag once the external source has failed.
// - Supply rising above threshold starts the reset sequence.
// - Supply below minimum level forces internal reset.
// - Supervision timer expiry causes a full internal reset.
// - Reset pin low halts digital logic; clock control keeps running.
// - Reset pin lows shorter than 1 us are ignored.
// - Internal reset holds until pin high plus 4096 timer cycles.
// - Processor starts fetching at address zero after reset release.
// - Interface select and address pins are sampled during reset.
// - Exactly one of UART, SPI or I2C is enabled at all times.
// - Pin A low gives SPI; A high, B low UART; both high I2C.
`default_nettype none

package clkrst_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS     = 50;
    localparam int unsigned STARTUP_CYCLES    = 1024;
    localparam int unsigned PIN_FILTER_NS     = 1000;
    // Least time, so round up
    localparam int unsigned PIN_FILTER_CYCLES = (PIN_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RESET_TIMER_CYCLES = 4096;
    localparam int unsigned SWITCH_GAP_CYCLES = 2;
    localparam int unsigned SUP_TIMEOUT_DEFAULT = 65536;

    localparam logic [9:0]  STARTUP_LAST  = 10'(STARTUP_CYCLES - 1);
    localparam logic [4:0]  FILTER_LAST   = 5'(PIN_FILTER_CYCLES - 1);
    localparam logic [11:0] RST_TMR_LAST  = 12'(RESET_TIMER_CYCLES - 1);
    localparam logic [1:0]  GAP_LAST      = 2'(SWITCH_GAP_CYCLES - 1);

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [23:0] RESET_VECTOR   = 24'h000000;
    localparam logic [1:0]  DEV_ADDR_RESET = 2'h0;

    typedef enum logic [1:0] {IFC_SPI, IFC_UART, IFC_I2C} ifc_e;
    typedef enum logic [2:0] {CS_RC_START, CS_RC, CS_GAP_TO_EXT, CS_EXT, CS_GAP_TO_RC} clk_state_e;

endpackage

`default_nettype wire

// ===== hw/rst_seq_if.sv
// Carrier between the manager top and its reset sequencer.
// Assumes both ends sit in the system clock domain.
`default_nettype none

interface rst_seq_if;
    logic pin_low;     // Synchronised reset pin, low seen
    logic por_fail;    // Supply below threshold
    logic sup_expire;  // Supervision timer ran out
    logic sys_rst;     // Internal reset level
    logic release_now; // Strobe in the last reset cycle

    modport seq (input pin_low, input por_fail, input sup_expire, output sys_rst, output release_now);
    modport top (output pin_low, output por_fail, output sup_expire, input sys_rst, input release_now);
endinterface

`default_nettype wire

// ===== hw/rst_sequencer.sv
// Reset pin filter, source merge and release timer.
// Assumes all inputs are already synchronous to CLK_SYS.
`default_nettype none

module rst_sequencer (
    input  wire logic clk,
    input  wire logic rst,
    rst_seq_if.seq    rs
);
    typedef struct packed {
        logic [4:0]  filt_cnt;
        logic        pin_rst;
        logic [11:0] tmr_cnt;
        logic        sys_rst;
    } seq_s;

    seq_s st;
    seq_s next_st;
    logic any_req;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Sources merged by OR; release only through the timer
    assign any_req = rs.por_fail | rs.sup_expire | st.pin_rst;
    assign rs.sys_rst = st.sys_rst;
    assign rs.release_now = st.sys_rst & ~any_req & (st.tmr_cnt == clkrst_pkg::RST_TMR_LAST);

    always_comb begin
        next_st = st;
        // Short lows never reach the counter end, so noise is dropped
        if (rs.pin_low) begin
            if (st.filt_cnt == clkrst_pkg::FILTER_LAST) begin
                next_st.pin_rst = 1'b1;
            end else begin
                next_st.filt_cnt = st.filt_cnt + 5'h01;
            end
        end else begin
            next_st.filt_cnt = 5'h00;
            next_st.pin_rst  = 1'b0;
        end
        // Timer restarts while any request stands
        if (any_req) begin
            next_st.sys_rst = 1'b1;
            next_st.tmr_cnt = 12'h000;
        end else if (st.sys_rst) begin
            if (rs.release_now) begin
                next_st.sys_rst = 1'b0;
            end else begin
                next_st.tmr_cnt = st.tmr_cnt + 12'h001;
            end
        end
    end

    // Power-up puts the sequencer in reset with the timer cleared
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '{filt_cnt: 5'h00, pin_rst: 1'b0, tmr_cnt: 12'h000, sys_rst: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_filter_fires: assert property (rs.pin_low && st.filt_cnt == clkrst_pkg::FILTER_LAST |=> st.pin_rst)
        else $error("filtered pin low did not raise reset");
    a_short_ignored: assert property (!rs.pin_low |=> !st.pin_rst)
        else $error("pin reset stands after pin went high");
    a_release_timed: assert property ($fell(st.sys_rst) |-> $past(st.tmr_cnt) == clkrst_pkg::RST_TMR_LAST)
        else $error("reset released before timer end");
    a_req_holds: assert property (any_req |=> st.sys_rst && st.tmr_cnt == 12'h000)
        else $error("request did not hold reset");
endmodule

`default_nettype wire

// ===== hw/clock_reset_manager.sv
// Clock source selection, supervision timer and reset merge.
// Assumes the gate enables drive a glitch-free clock gate per source.
`default_nettype none

module clock_reset_manager #(
    parameter int unsigned SUP_TIMEOUT = clkrst_pkg::SUP_TIMEOUT_DEFAULT
) (
    input  wire logic        CLK_SYS,
    input  wire logic        RST,
    input  wire logic        RESET_N,
    input  wire logic        DIGITAL_SUPPLY_RAIL_OK,
    input  wire logic        XTAL_OK,
    input  wire logic        SOFTWARE_SUPERVISION_TIMER_REFRESH,
    input  wire logic        INTERFACE_SELECT_PIN_A,
    input  wire logic        INTERFACE_SELECT_PIN_B,
    input  wire logic [1:0]  ADDR_PIN,
    output logic             SYS_RST,
    output logic             CPU_START,
    output logic [23:0]      FETCH_ADDR,
    output logic             RC_CLK_EN,
    output logic             EXT_CLK_EN,
    output logic             OSC_FAIL,
    output logic             EN_UART,
    output logic             EN_SPI,
    output logic             EN_I2C,
    output logic [1:0]       DEV_ADDR
);
    localparam logic [31:0] SUP_LAST = 32'(SUP_TIMEOUT - 1);

    typedef struct packed {
        logic [6:0]            sync1;
        logic [6:0]            sync2;
        clkrst_pkg::clk_state_e cs;
        logic [9:0]            start_cnt;
        logic [1:0]            gap_cnt;
        logic                  rc_restart;
        logic                  osc_fail;
        logic                  rst_seen;
        logic [31:0]           sup_cnt;
        logic                  sup_expire;
        clkrst_pkg::ifc_e      ifc;
        logic [1:0]            addr;
        logic [23:0]           fetch;
        logic                  start;
    } top_s;

    top_s st;
    top_s next_st;
    logic xtal_ok;
    logic sel_a;
    logic sel_b;

    rst_seq_if rs ();

    rst_sequencer u_seq (
        .clk (CLK_SYS),
        .rst (RST),
        .rs  (rs.seq)
    );

    // ------------------------------------------------------------
    // Synchronised pin view
    // ------------------------------------------------------------
    // Only the second stage is read; bit order matches sync1 load
    assign rs.pin_low    = ~st.sync2[0];
    assign rs.por_fail   = ~st.sync2[1];
    assign xtal_ok       = st.sync2[2];
    assign sel_a         = st.sync2[3];
    assign sel_b         = st.sync2[4];
    assign rs.sup_expire = st.sup_expire;

    function automatic clkrst_pkg::ifc_e decode_ifc(input logic a, input logic b);
        if (!a) begin
            decode_ifc = clkrst_pkg::IFC_SPI;
        end else if (!b) begin
            decode_ifc = clkrst_pkg::IFC_UART;
        end else begin
            decode_ifc = clkrst_pkg::IFC_I2C;
        end
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st       = st;
        next_st.sync1 = {ADDR_PIN, INTERFACE_SELECT_PIN_B, INTERFACE_SELECT_PIN_A, XTAL_OK,
                         DIGITAL_SUPPLY_RAIL_OK, RESET_N};
        next_st.sync2 = st.sync1;
        next_st.rst_seen = rs.sys_rst;
        next_st.start    = rs.release_now;

        // Clock control runs through pin reset; a new reset restarts start-up
        if (rs.sys_rst && !st.rst_seen) begin
            next_st.start_cnt = 10'h000;
            if (st.cs == clkrst_pkg::CS_EXT) begin
                // Close the external gate through a full dead gap first
                next_st.cs         = clkrst_pkg::CS_GAP_TO_RC;
                next_st.gap_cnt    = 2'h0;
                next_st.rc_restart = 1'b1;
                // A failure in the same cycle is still recorded
                if (!xtal_ok) begin
                    next_st.osc_fail = 1'b1;
                end
            end else if ((st.cs == clkrst_pkg::CS_GAP_TO_EXT || st.cs == clkrst_pkg::CS_GAP_TO_RC)
                         && st.gap_cnt != clkrst_pkg::GAP_LAST) begin
                // Gap already running: finish it, then start up on RC
                next_st.cs         = clkrst_pkg::CS_GAP_TO_RC;
                next_st.gap_cnt    = st.gap_cnt + 2'h1;
                next_st.rc_restart = 1'b1;
            end else begin
                next_st.cs         = clkrst_pkg::CS_RC_START;
                next_st.rc_restart = 1'b0;
            end
        end else begin
            unique case (st.cs)
                clkrst_pkg::CS_RC_START: begin
                    if (st.start_cnt == clkrst_pkg::STARTUP_LAST) begin
                        next_st.cs      = xtal_ok ? clkrst_pkg::CS_GAP_TO_EXT : clkrst_pkg::CS_RC;
                        next_st.gap_cnt = 2'h0;
                    end else begin
                        next_st.start_cnt = st.start_cnt + 10'h001;
                    end
                end
                clkrst_pkg::CS_RC: begin
                    if (xtal_ok) begin
                        next_st.cs      = clkrst_pkg::CS_GAP_TO_EXT;
                        next_st.gap_cnt = 2'h0;
                    end
                end
                clkrst_pkg::CS_GAP_TO_EXT: begin
                    // Both gates shut for the gap: trades a few cycles for no runt phase
                    if (st.gap_cnt == clkrst_pkg::GAP_LAST) begin
                        next_st.cs = xtal_ok ? clkrst_pkg::CS_EXT : clkrst_pkg::CS_RC;
                    end else begin
                        next_st.gap_cnt = st.gap_cnt + 2'h1;
                    end
                end
                clkrst_pkg::CS_EXT: begin
                    if (!xtal_ok) begin
                        next_st.cs       = clkrst_pkg::CS_GAP_TO_RC;
                        next_st.gap_cnt  = 2'h0;
                        next_st.osc_fail = 1'b1;
                    end
                end
                clkrst_pkg::CS_GAP_TO_RC: begin
                    if (st.gap_cnt == clkrst_pkg::GAP_LAST) begin
                        // A pending restart still owes the full start-up run
                        next_st.cs = st.rc_restart ? clkrst_pkg::CS_RC_START : clkrst_pkg::CS_RC;
                        next_st.rc_restart = 1'b0;
                    end else begin
                        next_st.gap_cnt = st.gap_cnt + 2'h1;
                    end
                end
                default: begin
                    next_st.cs = clkrst_pkg::CS_RC;
                end
            endcase
        end

        // Supervision timer: firmware refresh keeps it from running out
        next_st.sup_expire = 1'b0;
        if (rs.sys_rst || SOFTWARE_SUPERVISION_TIMER_REFRESH) begin
            next_st.sup_cnt = 32'h00000000;
        end else if (st.sup_cnt == SUP_LAST) begin
            next_st.sup_cnt    = 32'h00000000;
            next_st.sup_expire = 1'b1;
        end else begin
            next_st.sup_cnt = st.sup_cnt + 32'h00000001;
        end

        // Straps follow the pins during reset and freeze at release
        if (rs.sys_rst) begin
            next_st.ifc   = decode_ifc(sel_a, sel_b);
            next_st.addr  = st.sync2[6:5];
            next_st.fetch = clkrst_pkg::RESET_VECTOR;
        end
    end

    // Fail flag is sticky until a hard reset
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            st <= '{sync1: 7'h00, sync2: 7'h00, cs: clkrst_pkg::CS_RC_START, start_cnt: 10'h000,
                    gap_cnt: 2'h0, rc_restart: 1'b0, osc_fail: 1'b0, rst_seen: 1'b1, sup_cnt: 32'h00000000,
                    sup_expire: 1'b0, ifc: clkrst_pkg::IFC_SPI, addr: clkrst_pkg::DEV_ADDR_RESET,
                    fetch: clkrst_pkg::RESET_VECTOR, start: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign SYS_RST    = rs.sys_rst;
    assign CPU_START  = st.start;
    assign FETCH_ADDR = st.fetch;
    assign RC_CLK_EN  = (st.cs == clkrst_pkg::CS_RC_START) || (st.cs == clkrst_pkg::CS_RC);
    assign EXT_CLK_EN = (st.cs == clkrst_pkg::CS_EXT);
    assign OSC_FAIL   = st.osc_fail;
    // One-hot by construction of the enum
    assign EN_SPI     = (st.ifc == clkrst_pkg::IFC_SPI);
    assign EN_UART    = (st.ifc == clkrst_pkg::IFC_UART);
    assign EN_I2C     = (st.ifc == clkrst_pkg::IFC_I2C);
    assign DEV_ADDR   = st.addr;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    sequence s_ext_lost;
        EXT_CLK_EN && !xtal_ok;
    endsequence
    sequence s_gap_then_rc;
        !RC_CLK_EN && !EXT_CLK_EN ##2 RC_CLK_EN;
    endsequence

    a_startup_rc: assert property (st.cs == clkrst_pkg::CS_RC_START |-> RC_CLK_EN && !EXT_CLK_EN)
        else $error("external clock used during start-up");
    a_startup_len: assert property ($rose(rs.sys_rst) |=> st.start_cnt == 10'h000 &&
                                    (st.cs == clkrst_pkg::CS_RC_START || st.rc_restart))
        else $error("start-up did not restart with reset");
    a_auto_switch: assert property (st.cs == clkrst_pkg::CS_RC && xtal_ok |=> ##2 EXT_CLK_EN || !xtal_ok)
        else $error("no switch to present external clock");
    a_fallback_gap: assert property (s_ext_lost |=> s_gap_then_rc)
        else $error("fallback to RC clock not clean");
    a_fail_flag: assert property (s_ext_lost |=> OSC_FAIL ##1 OSC_FAIL)
        else $error("oscillator failure not recorded");
    a_gates_excl: assert property (!(RC_CLK_EN && EXT_CLK_EN))
        else $error("both clock gates open");
    a_supply_low: assert property (rs.por_fail |=> SYS_RST)
        else $error("low supply did not reset");
    a_sup_expiry: assert property (st.sup_expire |=> SYS_RST)
        else $error("timer expiry did not reset");
    a_one_iface: assert property ($onehot({EN_UART, EN_SPI, EN_I2C}))
        else $error("interface enables not one-hot");
    a_start_zero: assert property ($fell(SYS_RST) |-> CPU_START && FETCH_ADDR == 24'h000000)
        else $error("processor not started at zero");
    a_strap_freeze: assert property (!SYS_RST && !$rose(SYS_RST) |=> $stable(st.ifc) || SYS_RST)
        else $error("interface changed outside reset");
endmodule

`default_nettype wire

// ===== testbench/ext_party.sv
// Model of the far side: external reset driver and crystal source.
// Assumes the bench calls its tasks just after a falling clock edge.
`default_nettype none

module ext_party (
    input  wire logic clk,
    output var  logic reset_n,
    output var  logic xtal_ok
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Idle state
    // ------------------------------------------------------------
    // Pull-up keeps the pin high; crystal absent until told
    initial begin
        reset_n = 1'h1;
        xtal_ok = 1'h0;
    end

    // ------------------------------------------------------------
    // Commands
    // ------------------------------------------------------------
    // Whole cycles only; a caller may ask for too short a low on purpose
    task automatic pin_low(input int cycles);
        reset_n = 1'h0;
        repeat (cycles) @(negedge clk);
        reset_n = 1'h1;
    endtask

    // Oscillator good or failed, as a level
    task automatic set_osc(input logic good);
        xtal_ok = good;
    endtask
endmodule

`default_nettype wire

// ===== testbench/tb_clock_reset_manager.sv
// Self-checking bench for the clock and reset manager.
// Assumes ext_party stands in for the reset driver and crystal.
`default_nettype none

module tb_clock_reset_manager;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int SUP = 64; // Short supervision timeout keeps the run brief

    logic        clk_sys   = 1'h0;
    logic        rst       = 1'h1;
    logic        supply_ok = 1'h1;
    logic        refresh   = 1'h0;
    logic        pin_a     = 1'h0;
    logic        pin_b     = 1'h0;
    logic [1:0]  addr      = 2'h0;
    logic        reset_n, xtal_ok, sys_rst, cpu_start, rc_en, ext_en, osc_fail;
    logic        en_uart, en_spi, en_i2c;
    logic [23:0] fetch;
    logic [1:0]  dev_addr;
    int          n_mismatch  = 0;
    int          comparisons = 0;
    int          seed        = 32'h14F058CB;
    int          cyc         = 0;
    int          gap         = 0;
    bit          refresh_on  = 1'h1;

    // ------------------------------------------------------------
    // Design and far side
    // ------------------------------------------------------------
    clock_reset_manager #(.SUP_TIMEOUT(SUP)) clock_reset_manager_i (
        .CLK_SYS(clk_sys), .RST(rst), .RESET_N(reset_n), .DIGITAL_SUPPLY_RAIL_OK(supply_ok),
        .XTAL_OK(xtal_ok), .SOFTWARE_SUPERVISION_TIMER_REFRESH(refresh),
        .INTERFACE_SELECT_PIN_A(pin_a), .INTERFACE_SELECT_PIN_B(pin_b), .ADDR_PIN(addr),
        .SYS_RST(sys_rst), .CPU_START(cpu_start), .FETCH_ADDR(fetch), .RC_CLK_EN(rc_en),
        .EXT_CLK_EN(ext_en), .OSC_FAIL(osc_fail), .EN_UART(en_uart), .EN_SPI(en_spi),
        .EN_I2C(en_i2c), .DEV_ADDR(dev_addr));
    ext_party ext_party_i (.clk(clk_sys), .reset_n(reset_n), .xtal_ok(xtal_ok));

    // ------------------------------------------------------------
    // Model and compares
    // ------------------------------------------------------------
    // Expected enables as {uart, spi, i2c}
    function automatic logic [2:0] exp_ifc(input logic a, input logic b);
        return !a ? 3'h2 : (b ? 3'h1 : 3'h4);
    endfunction

    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic chk_vec(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int lo, input int hi);
        comparisons++;
        if (got < lo || got > hi) begin
            n_mismatch++;
            $display("[ERR] %0t got %0h exp %0h..%0h", $time, got, lo, hi);
        end
    endtask

    // Bounded wait on SYS_RST (0), EXT_CLK_EN (1) or RC_CLK_EN (2)
    task automatic wait_for(input int sel, input logic v, input int max, output int n);
        logic s;
        n = 0;
        forever begin
            case (sel)
                0: s = sys_rst;
                1: s = ext_en;
                default: s = rc_en;
            endcase
            if (s === v || n >= max) break;
            @(negedge clk_sys);
            n++;
        end
    endtask

    // Release timing, start strobe, vector and frozen straps
    task automatic check_release(input int t0, input int lo, input int hi);
        int          n;
        int          sum;
        logic [2:0]  e;
        logic [1:0]  a;
        e = exp_ifc(pin_a, pin_b);
        a = addr;
        sum = 0;
        wait_for(0, 1'h0, 6000, n);
        chk_cnt(cyc - t0, lo, hi);
        repeat (3) begin
            sum += int'(cpu_start === 1'h1);
            @(negedge clk_sys);
        end
        chk_cnt(sum, 1, 1);
        chk_vec(fetch, 24'h000000);
        chk_vec({19'h0, en_uart, en_spi, en_i2c, dev_addr}, {19'h0, e, a});
        {pin_a, pin_b, addr} = 4'($random(seed));
        repeat (4) @(negedge clk_sys);
        chk_vec({19'h0, en_uart, en_spi, en_i2c, dev_addr}, {19'h0, e, a});
    endtask

    task automatic summarize();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock, firmware refresh and clock-gate monitor
    // ------------------------------------------------------------
    always #25 clk_sys = ~clk_sys;

    // Refresh every 16 cycles, well inside the timeout; overlap or runt gap is a glitch
    always @(negedge clk_sys) begin
        cyc++;
        refresh <= refresh_on && (cyc % 16 == 0);
        if (!rst) begin
            chk_bit(rc_en & ext_en, 1'h0);
            if (!rc_en && !ext_en) begin
                gap++;
            end else if (gap != 0) begin
                chk_cnt(gap, 2, 2);
                gap = 0;
            end
        end
    end

    // Hang guard, well beyond the roughly 30k cycles the tests need
    initial begin
        #3000000;
        n_mismatch++;
        summarize();
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        int n;
        int t0;
        {pin_a, pin_b, addr} = 4'($random(seed));
        repeat (2) @(negedge clk_sys);
        ext_party_i.set_osc(1'h1);
        rst = 1'h0;
        t0 = cyc;
        // Crystal present from the start: RC first, then the switch
        wait_for(1, 1'h1, 1040, n);
        chk_cnt(n, 1024, 1032);
        chk_bit(osc_fail, 1'h0);
        check_release(t0, 4096, 4104);
        // Crystal fails, then recovers; failure flag is sticky
        ext_party_i.set_osc(1'h0);
        wait_for(2, 1'h1, 12, n);
        chk_cnt(n, 3, 8);
        chk_bit(osc_fail, 1'h1);
        ext_party_i.set_osc(1'h1);
        wait_for(1, 1'h1, 12, n);
        chk_cnt(n, 3, 8);
        // Too short a low on the pin must not reset
        ext_party_i.pin_low(15);
        repeat (30) begin
            chk_bit(sys_rst, 1'h0);
            @(negedge clk_sys);
        end
        // Exactly the minimum low resets; clock control keeps working
        ext_party_i.pin_low(20);
        t0 = cyc;
        wait_for(0, 1'h1, 8, n);
        chk_cnt(n, 1, 5);
        wait_for(2, 1'h1, 8, n);
        chk_cnt(n, 0, 6);
        chk_bit(osc_fail, 1'h1);
        check_release(t0, 4097, 4104);
        // Firmware stops refreshing: supervision expiry resets
        @(posedge refresh);
        refresh_on = 1'h0;
        wait_for(0, 1'h1, SUP + 20, n);
        chk_cnt(n, SUP, SUP + 3);
        refresh_on = 1'h1;
        t0 = cyc;
        check_release(t0, 4095, 4100);
        // Supply dips, one per strap combination
        // First dip also loses the crystal: start-up ends on RC, then switches
        for (int k = 0; k < 4; k++) begin
            if (k == 0) begin
                ext_party_i.set_osc(1'h0);
            end
            supply_ok = 1'h0;
            {pin_a, pin_b} = 2'(k);
            addr = 2'(3 - k);
            wait_for(0, 1'h1, 10, n);
            chk_cnt(n, 1, 5);
            repeat (5) @(negedge clk_sys);
            supply_ok = 1'h1;
            t0 = cyc;
            check_release(t0, 4096, 4104);
            if (k == 0) begin
                ext_party_i.set_osc(1'h1);
                wait_for(1, 1'h1, 12, n);
                chk_cnt(n, 3, 8);
            end
        end
        summarize();
    end
endmodule

`default_nettype wire
